// ---- include/lcis_pkg.sv ----
// shared constants and types for the link controller interrupt/status block
package lcis_pkg;

    // register select value for the main control/status register
    localparam logic [2:0] CSR_ZERO_SEL = 3'h0;

    // bit positions in the main control/status register
    localparam int BIT_IRQ_ENABLE = 9;
    localparam int BIT_IRQ_FLAG   = 8;
    localparam int BIT_CAUSE_LO   = 1;
    localparam int BIT_CAUSE_HI   = 7;
    localparam int BIT_ZERO       = 0;

    localparam int  REG_WIDTH      = 16;
    localparam int  CAUSE_WIDTH    = 7;

    // reset values
    localparam logic       IRQ_ENABLE_RST = 1'h0;
    localparam logic [6:0] CAUSE_RST      = 7'h00;
    localparam logic       STOPPED_RST    = 1'h1;

    // memory ready time-out, in system clock cycles
    localparam int MEM_TIMEOUT_CYC = 256;
    localparam int MEM_CNT_WIDTH   = 9;

    // cause flags in register order, bit 7 down to bit 1
    typedef struct packed {
        logic mem_timeout_err;
        logic missed_frame;
        logic rx_fifo_overrun;
        logic tx_fifo_underrun;
        logic provider_prim_event;
        logic tx_done_event;
        logic rx_done_event;
    } lcis_cause_t;

    // protocol side effects requested from the frame engine
    typedef struct packed {
        logic release_bus;
        logic rx_off;
        logic tx_off;
        logic rx_ring_clear;
        logic send_rnr;
        logic send_rr;
        logic rx_fifo_flush;
        logic reuse_rx_bufs;
        logic tx_abort;
    } lcis_action_t;

endpackage

// ---- design/lcis_irq_status.sv ----
// interrupt and event-status logic of the main control/status register
//
// Contract
// RL1 - pin low when enable and flag set
// RL2 - pin high whenever enable is zero
// RL3 - enable read/write, cleared by stop, reset
// RL4 - flag is OR of seven causes
// RL5 - flag falls when causes cleared
// RL6 - memory error after 256 cycles without ready
// RL7 - memory error releases bus, stops receiver, transmitter
// RL8 - missed frame sets flag, clears ring active
// RL9 - missed frame: local busy, RNR; clear: RR
// RL10 - overrun sets flag, flushes fifo, reuses buffers
// RL11 - transmit underrun aborts frame, sets flag
// RL12 - primitive update sets provider event flag
// RL13 - transmit descriptor update sets done flag
// RL14 - receive descriptor update sets done flag
// RL15 - device sets causes; host writes one clears
// RL16 - bit zero reads as zero always
// RL17 - host stop primitive halts dma activity; stop here only clears causes, enable, local busy and the time-out wait
// RL18 - timeout counter restarts; simultaneous causes independent
module lcis_irq_status #(
    parameter int TIMEOUT_CYC = lcis_pkg::MEM_TIMEOUT_CYC
) (
    input  wire logic                 sys_clk_in,
    input  wire logic                 resetn_in,
    // register port
    input  wire logic [2:0]           reg_sel_in,
    input  wire logic                 reg_wr_in,
    input  wire logic [15:0]          reg_wdata_in,
    output logic [15:0]               reg_rdata_out,
    // primitive processing
    input  wire logic                 stop_prim_in,
    input  wire logic                 start_prim_in,
    // bus master memory cycle
    input  wire logic                 bus_master_in,
    input  wire logic                 mem_addr_drive_in,
    input  wire logic                 mem_ready_in,
    // frame engine events
    input  wire logic                 link_established_in,
    input  wire logic                 missed_frame_in,
    input  wire logic                 rx_has_data_in,
    input  wire logic                 rx_fifo_full_in,
    input  wire logic                 tx_in_frame_in,
    input  wire logic                 tx_empty_in,
    input  wire logic                 tx_fifo_empty_in,
    input  wire logic                 prim_reg_updated_in,
    input  wire logic                 tx_desc_updated_in,
    input  wire logic                 rx_desc_updated_in,
    // outputs
    output logic                      irq_n_out,
    output logic                      local_busy_out,
    output lcis_pkg::lcis_action_t    action_out
);

    logic                  irq_enable_q;
    logic                  irq_enable_d;
    lcis_pkg::lcis_cause_t cause_q;
    lcis_pkg::lcis_cause_t cause_d;
    lcis_pkg::lcis_cause_t cause_set;
    lcis_pkg::lcis_cause_t cause_clr;
    logic                  stopped_q;
    logic                  ready_meta_q;
    logic                  ready_sync_q;
    logic                  wait_q;
    logic [lcis_pkg::MEM_CNT_WIDTH-1:0] cnt_q;
    logic                  local_busy_q;
    logic [15:0]           rdata_q;
    lcis_pkg::lcis_action_t action_q;

    // register select decode, shared by write strobe and read image
    function automatic logic sel_is_csr(input logic [2:0] s);
        return s == lcis_pkg::CSR_ZERO_SEL;
    endfunction

    // shared-stop: bus reset is handled by the synchronous reset path
    wire csr_wr      = reg_wr_in && sel_is_csr(reg_sel_in);
    wire irq_flag    = |cause_q;                                                        // [RL4] [RL5]
    wire timeout_hit = wait_q && !ready_sync_q
                       && (cnt_q == lcis_pkg::MEM_CNT_WIDTH'(TIMEOUT_CYC - 1));           // [RL6]
    wire overrun     = rx_has_data_in && rx_fifo_full_in;                               // [RL10]
    wire underrun    = tx_in_frame_in && tx_empty_in && tx_fifo_empty_in;              // [RL11]
    wire miss_clear  = csr_wr && reg_wdata_in[lcis_pkg::BIT_CAUSE_LO + 5] && cause_q.missed_frame;

    // event sources, each captured on its own bit
    assign cause_set.mem_timeout_err     = timeout_hit;                                 // [RL6] [RL18]
    assign cause_set.missed_frame        = missed_frame_in;                             // [RL8]
    assign cause_set.rx_fifo_overrun     = overrun;                                     // [RL10]
    assign cause_set.tx_fifo_underrun    = underrun;                                    // [RL11]
    assign cause_set.provider_prim_event = prim_reg_updated_in;                         // [RL12]
    assign cause_set.tx_done_event       = tx_desc_updated_in;                          // [RL13]
    assign cause_set.rx_done_event       = rx_desc_updated_in;                          // [RL14]

    // write one to clear; zero leaves a flag alone
    assign cause_clr = csr_wr ? reg_wdata_in[lcis_pkg::BIT_CAUSE_HI:lcis_pkg::BIT_CAUSE_LO]
                              : lcis_pkg::CAUSE_RST;                                    // [RL15]
    // set wins over a clear in the same cycle; stop clears all
    assign cause_d = stop_prim_in ? lcis_pkg::CAUSE_RST
                                  : ((cause_q & ~cause_clr) | cause_set);               // [RL15] [RL18]

    // enable ignores writes of one while stopped
    assign irq_enable_d = stop_prim_in ? 1'h0
                        : csr_wr ? (reg_wdata_in[lcis_pkg::BIT_IRQ_ENABLE] && !stopped_q)
                        : irq_enable_q;                                                 // [RL3]

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            irq_enable_q <= lcis_pkg::IRQ_ENABLE_RST;
            cause_q      <= lcis_pkg::CAUSE_RST;
            stopped_q    <= lcis_pkg::STOPPED_RST;
        end else begin
            irq_enable_q <= irq_enable_d;                                               // [RL3]
            cause_q      <= cause_d;                                                    // [RL15]
            if (stop_prim_in) begin
                stopped_q <= 1'h1;
            end else if (start_prim_in) begin
                stopped_q <= 1'h0;
            end
        end
    end

    // ready pin crosses in through two flops
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ready_meta_q <= 1'h0;
            ready_sync_q <= 1'h0;
        end else begin
            ready_meta_q <= mem_ready_in;
            ready_sync_q <= ready_meta_q;
        end
    end

    // memory time-out counter
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            wait_q <= 1'h0;
            cnt_q  <= '0;
        end else if (stop_prim_in || !bus_master_in || ready_sync_q || timeout_hit) begin
            wait_q <= 1'h0;                                                             // [RL18]
            cnt_q  <= '0;
        end else if (mem_addr_drive_in) begin
            wait_q <= 1'h1;                                                             // [RL18]
            cnt_q  <= '0;
        end else if (wait_q) begin
            cnt_q  <= cnt_q + 1'h1;                                                     // [RL6]
        end
    end

    // local busy state around a missed frame
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            local_busy_q <= 1'h0;
        end else if (stop_prim_in) begin
            local_busy_q <= 1'h0;
        end else if (missed_frame_in && link_established_in) begin
            local_busy_q <= 1'h1;                                                       // [RL9]
        end else if (miss_clear) begin
            local_busy_q <= 1'h0;                                                       // [RL9]
        end
    end

    // action pulses to the frame engine, registered one cycle after their events
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            action_q <= '0;
        end else begin
            action_q.release_bus   <= timeout_hit;                                      // [RL7]
            action_q.rx_off        <= timeout_hit;                                      // [RL7]
            action_q.tx_off        <= timeout_hit;                                      // [RL7]
            action_q.rx_ring_clear <= missed_frame_in;                                  // [RL8]
            action_q.send_rnr      <= missed_frame_in && link_established_in
                                      && !local_busy_q;                                 // [RL9]
            action_q.send_rr       <= miss_clear && local_busy_q
                                      && !(missed_frame_in && link_established_in);     // [RL9]
            action_q.rx_fifo_flush <= overrun;                                          // [RL10]
            action_q.reuse_rx_bufs <= overrun;                                          // [RL10]
            action_q.tx_abort      <= underrun;                                         // [RL11]
        end
    end

    // register read image
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rdata_q <= 16'h0000;
        end else if (sel_is_csr(reg_sel_in)) begin
            rdata_q <= {6'h00, irq_enable_q, irq_flag, cause_q, 1'h0};                  // [RL16]
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign irq_n_out      = !(irq_enable_q && irq_flag);                                // [RL1] [RL2]
    assign reg_rdata_out  = rdata_q;
    assign local_busy_out = local_busy_q;
    assign action_out     = action_q;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_addr_start;
        bus_master_in && mem_addr_drive_in && !wait_q && !ready_sync_q && !stop_prim_in;
    endsequence

    sequence s_no_ready_wait;
        (bus_master_in && !ready_sync_q && !mem_addr_drive_in && !stop_prim_in) [*8];
    endsequence

    a_irq_pin_low: assert property (irq_enable_q && irq_flag |-> !irq_n_out)          // [RL1]
        else $error("interrupt pin not low while enabled and pending");

    a_irq_pin_high: assert property (!irq_enable_q |-> irq_n_out)                     // [RL2]
        else $error("interrupt pin low while disabled");

    a_enable_stop_block: assert property (stopped_q && !start_prim_in |=> !irq_enable_q || $past(irq_enable_q)) // [RL3]
        else $error("interrupt enable set while stopped");

    a_flag_or_causes: assert property (reg_sel_in == lcis_pkg::CSR_ZERO_SEL
        |=> reg_rdata_out[lcis_pkg::BIT_IRQ_FLAG] == |reg_rdata_out[7:1])               // [RL4]
        else $error("flag bit differs from cause bits");

    a_stop_clears_all: assert property (stop_prim_in |=> cause_q == '0 && !irq_enable_q && irq_n_out) // [RL5]
        else $error("stop left flags or enable set");

    a_timeout_count: assert property (s_addr_start ##1 s_no_ready_wait |-> cnt_q == 9'h007 || !wait_q) // [RL18]
        else $error("time-out counter not counting from the address");

    a_timeout_mem_timeout_err: assert property (timeout_hit && !stop_prim_in |=> cause_q.mem_timeout_err && action_out.release_bus
        && action_out.rx_off && action_out.tx_off)                                      // [RL6]
        else $error("time-out did not raise memory error and shutdown");

    a_miss_ring: assert property (missed_frame_in && !stop_prim_in
        |=> cause_q.missed_frame && action_out.rx_ring_clear)                           // [RL8]
        else $error("missed frame not flagged or ring left active");

    a_busy_rnr: assert property (missed_frame_in && link_established_in && !local_busy_q && !stop_prim_in
        |=> local_busy_out && action_out.send_rnr ##1 !action_out.send_rnr)             // [RL9]
        else $error("local busy entry without single RNR");

    a_overrun_flush: assert property (overrun && !stop_prim_in
        |=> cause_q.rx_fifo_overrun && action_out.rx_fifo_flush && action_out.reuse_rx_bufs) // [RL10]
        else $error("overrun not flagged or fifo not flushed");

    a_underrun_abort: assert property (underrun && !stop_prim_in
        |=> cause_q.tx_fifo_underrun && action_out.tx_abort)                            // [RL11]
        else $error("underrun not flagged or frame not aborted");

    a_set_beats_clear: assert property (csr_wr && reg_wdata_in[3] && prim_reg_updated_in && !stop_prim_in
        |=> cause_q.provider_prim_event)                                                // [RL12] [RL15]
        else $error("provider event lost against clear");

    a_done_events: assert property ((tx_desc_updated_in || rx_desc_updated_in) && !stop_prim_in
        |=> (cause_q.tx_done_event || !$past(tx_desc_updated_in))
         && (cause_q.rx_done_event || !$past(rx_desc_updated_in)))                      // [RL13] [RL14]
        else $error("done event not captured");

    a_zero_write_keeps: assert property (csr_wr && reg_wdata_in[7:1] == 7'h00 && !stop_prim_in
        |=> (cause_q & $past(cause_q)) == $past(cause_q))                               // [RL15]
        else $error("writing zero cleared a flag");

    a_bit_zero_low: assert property (!reg_rdata_out[lcis_pkg::BIT_ZERO])               // [RL16]
        else $error("bit zero read as one");

    // enable bit write behaviour
    a_enable_write_one: assert property (                                              // [RL3]
        csr_wr && reg_wdata_in[9] && !stopped_q && !stop_prim_in |=> irq_enable_q)
        else $error("enable not set by writing one");

    a_enable_write_zero: assert property (                                             // [RL3]
        csr_wr && !reg_wdata_in[9] && !stop_prim_in |=> !irq_enable_q)
        else $error("enable not cleared by writing zero");

    a_enable_holds: assert property (                                                  // [RL3]
        !csr_wr && !stop_prim_in |=> irq_enable_q == $past(irq_enable_q))
        else $error("enable changed without a write");

    // aggregate flag and write-one-clear behaviour
    a_flag_write_ignored: assert property (                                            // [RL4]
        csr_wr && reg_wdata_in[8] && cause_q == '0 && cause_set == '0 |=> !irq_flag)
        else $error("flag bit took a write");

    a_flag_falls: assert property (                                                    // [RL5]
        csr_wr && (cause_q & ~reg_wdata_in[7:1]) == 7'h00 && cause_set == '0 |=> irq_n_out && !irq_flag)
        else $error("flag stayed up after all causes cleared");

    a_one_clears: assert property (                                                    // [RL15]
        csr_wr && reg_wdata_in[1] && !rx_desc_updated_in && !stop_prim_in |=> !cause_q.rx_done_event)
        else $error("writing one did not clear receive done");

    // local busy exit and entry
    a_miss_clear_rr: assert property (                                                 // [RL9]
        miss_clear && local_busy_q && !missed_frame_in && !stop_prim_in |=> action_out.send_rr && !local_busy_out)
        else $error("clearing missed frame did not send RR");

    a_no_busy_unlinked: assert property (                                              // [RL9]
        !local_busy_q && !link_established_in |=> !local_busy_q)
        else $error("local busy entered without a link");

    // action pulses follow their events; bus release lasts one cycle
    a_release_single: assert property (                                                // [RL7]
        action_out.release_bus |=> !action_out.release_bus)
        else $error("bus release pulse longer than one cycle");

    a_ring_clear_cause: assert property (                                              // [RL8]
        action_out.rx_ring_clear |-> $past(missed_frame_in))
        else $error("ring clear without missed frame");

    a_flush_cause: assert property (                                                   // [RL10]
        action_out.rx_fifo_flush |-> $past(overrun))
        else $error("fifo flush without overrun");

    a_abort_cause: assert property (                                                   // [RL11]
        action_out.tx_abort |-> $past(underrun))
        else $error("frame abort without underrun");

    // time-out counter control
    a_ready_cancels: assert property (                                                 // [RL18]
        ready_sync_q |=> !wait_q)
        else $error("ready did not cancel the wait");

    a_addr_starts: assert property (                                                   // [RL18]
        bus_master_in && mem_addr_drive_in && !ready_sync_q && !stop_prim_in && !timeout_hit
        |=> wait_q && cnt_q == '0)
        else $error("address did not start the time-out count");

    a_no_wait_no_err: assert property (!wait_q |-> !timeout_hit)                       // [RL6]
        else $error("time-out raised with no memory cycle");

    // read image outside this register and above bit 9
    a_other_sel_zero: assert property (                                                // [RL16]
        !sel_is_csr(reg_sel_in) |=> reg_rdata_out == 16'h0000)
        else $error("unmapped select read nonzero");

    a_upper_bits_zero: assert property (reg_rdata_out[15:10] == 6'h00)                 // [RL16]
        else $error("upper read bits not zero");

endmodule

// ---- test/lcis_host_model.sv ----
// host processor model driving the register port and the primitives
module lcis_host_model (
    input  wire logic        sys_clk_in,
    input  wire logic [15:0] reg_rdata_in,
    output logic [2:0]       reg_sel_out,
    output logic             reg_wr_out,
    output logic [15:0]      reg_wdata_out,
    output logic             stop_prim_out,
    output logic             start_prim_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_sel_out = 3'h0;
        reg_wr_out = 1'b0;
        reg_wdata_out = 16'h0000;
        stop_prim_out = 1'b0;
        start_prim_out = 1'b0;
    end
    // one-word write; ones in cause bits clear them, data inverted once released
    task automatic wr16(input logic [15:0] d);
        @(negedge sys_clk_in);
        reg_sel_out = 3'h0;
        reg_wr_out = 1'b1;
        reg_wdata_out = d;
        @(negedge sys_clk_in);
        reg_wr_out = 1'b0;
        reg_wdata_out = ~d;
    endtask
    task automatic rd16(input logic [2:0] s, output logic [15:0] d);
        @(negedge sys_clk_in);
        reg_sel_out = s;
        @(negedge sys_clk_in);
        d = reg_rdata_in;
    endtask
    // stop (code zero with pending bit) or start primitive
    task automatic prim(input logic stop);
        @(negedge sys_clk_in);
        stop_prim_out = stop;
        start_prim_out = !stop;
        @(negedge sys_clk_in);
        stop_prim_out = 1'b0;
        start_prim_out = 1'b0;
    endtask
endmodule

// ---- test/link_ctrl_irq_status_test.sv ----
// self-checking bench for the interrupt and event-status block
module link_ctrl_irq_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TO = 16;
    logic                   sys_clk_in, resetn_in, bm, addr, rdy, link;
    logic [6:1]             ev;
    logic [2:0]             sel;
    logic                   wr, stp, sta, irq_n, busy;
    logic [15:0]            wd, rd;
    lcis_pkg::lcis_action_t act_w;
    int                     mismatches, check_count, cyc, seed, n, k;
    logic [31:0]            r;
    logic [6:0]             cv;
    logic                   rxd, rxf, txf, txe, txfe;
    logic [15:0]            rv;

    lcis_host_model i_host (.sys_clk_in(sys_clk_in), .reg_rdata_in(rd), .reg_sel_out(sel), .reg_wr_out(wr),
        .reg_wdata_out(wd), .stop_prim_out(stp), .start_prim_out(sta));
    lcis_irq_status #(.TIMEOUT_CYC(TO)) i_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .reg_sel_in(sel), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rd), .stop_prim_in(stp),
        .start_prim_in(sta), .bus_master_in(bm), .mem_addr_drive_in(addr), .mem_ready_in(rdy),
        .link_established_in(link), .missed_frame_in(ev[6]), .rx_has_data_in(rxd), .rx_fifo_full_in(rxf),
        .tx_in_frame_in(txf), .tx_empty_in(txe), .tx_fifo_empty_in(txfe), .prim_reg_updated_in(ev[3]),
        .tx_desc_updated_in(ev[2]), .rx_desc_updated_in(ev[1]), .irq_n_out(irq_n), .local_busy_out(busy),
        .action_out(act_w));

    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    function automatic logic [15:0] csr(input logic en, input logic [6:0] c);
        csr = {6'h00, en, |c, c, 1'b0};
    endfunction
    function automatic logic [15:0] exp_act(input logic [6:1] c, input logic lk);
        exp_act = {7'h00, 3'h0, c[6], c[6] & lk, 1'b0, c[5], c[5], c[4]};
    endfunction

    task automatic close_out();
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [15:0] e);
        logic [15:0] d;
        i_host.rd16(3'h0, d);
        chk(nm, e, d);
    endtask
    // event pulse for one cycle, then action pulse sampled
    task automatic fire(input logic [6:1] c, input logic lk);
        logic [31:0] sp;
        @(negedge sys_clk_in);
        sp = $random(seed);
        ev = c;
        // partial overrun and underrun patterns that must not trigger
        rxd = c[5] | sp[0];
        rxf = c[5] | (sp[1] & !sp[0]);
        txf = c[4] | sp[2];
        txe = c[4] | sp[3];
        txfe = c[4] | (sp[4] & !(sp[2] & sp[3]));
        @(negedge sys_clk_in);
        ev = 6'h00;
        {rxd, rxf, txf, txe, txfe} = 5'h00;
        chk("action", exp_act(c, lk), {7'h00, act_w});
    endtask

    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        {mismatches, check_count, cyc} = '0;
        seed = 1093;
        {bm, addr, rdy, link, ev} = '0;
        {rxd, rxf, txf, txe, txfe} = 5'h00;
        resetn_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        resetn_in = 1'b1;
        chk("irq_n", 16'h0001, {15'h0, irq_n});
        rchk("csr reset", 16'h0000);
        i_host.wr16(16'h0200);
        rchk("enable while stopped", 16'h0000);
        i_host.prim(1'b0);
        i_host.wr16(16'h0200);
        rchk("enable set", 16'h0200);
        i_host.rd16(3'h5, rv);
        chk("unmapped", 16'h0000, rv);
        for (n = 0; n < 24; n++) begin
            r = $random(seed);
            cv = 7'h01 << (r[2:0] % 6);
            fire(cv[5:0], 1'b0);
            chk("irq_n set", 16'h0000, {15'h0, irq_n});
            rchk("cause set", csr(1'b1, cv));
            i_host.wr16({r[15:10], 1'b1, r[8], 7'h00, r[0]});
            rchk("write zero", csr(1'b1, cv));
            i_host.wr16({r[15:10], 1'b1, r[8], cv, r[0]});
            rchk("cleared", csr(1'b1, 7'h00));
            chk("irq_n idle", 16'h0001, {15'h0, irq_n});
        end
        fire(6'h3F, 1'b0);
        rchk("all causes", csr(1'b1, 7'h3F));
        i_host.wr16(16'h0000);
        chk("irq_n masked", 16'h0001, {15'h0, irq_n});
        i_host.wr16(16'h007C);
        rchk("one cause left", csr(1'b0, 7'h01));
        i_host.prim(1'b1);
        rchk("after stop", 16'h0000);
        i_host.prim(1'b0);
        i_host.wr16(16'h0200);
        link = 1'b1;
        fire(6'h20, 1'b1);
        chk("local busy", 16'h0001, {15'h0, busy});
        i_host.wr16(16'h0240);
        chk("ready resp", 16'h0008, {7'h00, act_w});
        chk("busy left", 16'h0000, {15'h0, busy});
        bm = 1'b1;
        @(negedge sys_clk_in);
        addr = 1'b1;
        @(negedge sys_clk_in);
        addr = 1'b0;
        for (k = 1; k < 60 && act_w.release_bus !== 1'b1; k++)
            @(negedge sys_clk_in);
        chk("timeout window", 16'h0001, {15'h0, k >= TO && k <= TO + 3});
        chk("timeout action", 16'h01C0, {7'h00, act_w});
        rchk("mem error", csr(1'b1, 7'h40));
        i_host.wr16(16'h0280);
        @(negedge sys_clk_in);
        addr = 1'b1;
        @(negedge sys_clk_in);
        addr = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        rdy = 1'b1;
        repeat (3 * TO) @(negedge sys_clk_in);
        rdy = 1'b0;
        rchk("ready in time", csr(1'b1, 7'h00));
        close_out();
    end
endmodule
